//--- verilog/station_io_pkg.sv
/*
 * shared constants of the station glue logic: register byte offsets,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz host bus clock.
 */
package station_io_pkg;
	// register byte offsets on the host bus
	localparam logic [7:0]  OFS_INPUT_A     = 8'h00; // general input port, low 32 bits
	localparam logic [7:0]  OFS_INPUT_B     = 8'h04; // general input port, upper 8 bits
	localparam logic [7:0]  OFS_OUTPUT      = 8'h08; // general_output_port
	localparam logic [7:0]  OFS_RESET_CAUSE = 8'h0c; // sticky reset causes, write 1 clears
	localparam logic [7:0]  OFS_IRQ_PEND    = 8'h10; // pending flags, write 1 clears
	localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14; // 1 lets a source reach the line
	localparam logic [7:0]  OFS_CONTROL     = 8'h18; // edge select and audio select
	localparam logic [7:0]  OFS_SERIAL_ID   = 8'h1c; // serial identification, read only
	localparam logic [7:0]  OFS_STATUS      = 8'h20; // reference loss and lamp phase
	// field positions
	localparam int          CTL_DAC_EDGE    = 0;     // 1 falling edge, 0 rising edge
	localparam int          CTL_AUDIO_LSB   = 1;     // audio select, bits 3:1
	localparam int          LED_FAIL_BIT    = 6;     // the one active-low lamp
	localparam int          IRQ_DAC_BIT     = 1;     // dac voltage status source
	localparam int          BTN_LSB         = 4;     // pushbuttons at bits 7:4
	// reset values
	localparam logic [31:0] OUTPUT_RST      = 32'h0000_0000;
	localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;
	localparam logic [3:0]  CONTROL_RST     = 4'h0;
	// lamp patterns on the eight front panel lines
	localparam logic [7:0]  LED_ALL_LIT     = 8'hbf;
	localparam logic [7:0]  LED_ALL_DARK    = 8'h40;
	// timing
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          LAMP_ON_NS      = 200000000;
	localparam int          LAMP_OFF_NS     = 1000000000;
	localparam int          LAMP_ON_CYC     = LAMP_ON_NS / CLK_PERIOD_NS;
	localparam int          LAMP_OFF_CYC    = (LAMP_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- verilog/station_io_glue_logic.sv
/*
 * host-mapped glue logic of the station controller: input ports, the
 * registered output port, reference loss, reset gathering, masked host
 * interrupt, serial id, front panel lamps with lamp test, audio select.
 * assumes a single 100 MHz clock; bus strobes are one-cycle and synchronous.
 */
// What this block does
// - two readable input ports, forty bits total
// - readable 32-bit host-written output port
// - record reference loss for host reading
// - merge five reset sources into board reset
// - keep readable record of reset causes
// - host interrupt from eight monitored inputs
// - per-source mask and host clear
// - dac status edge polarity host selectable
// - serial id captured, readable, not writable
// - output bits 7..0 drive eight lamps
// - fail lamp lit low, others lit high
// - after reset only fail lamp lit
// - lamp test, dark one second, then function
// - host selects one of eight audio sources
// - pushbuttons on input bits 7..4, high pressed
`timescale 1ns/10ps
module station_io_glue_logic
	import station_io_pkg::*;
#(
	parameter int LAMP_ON_CYCLES  = LAMP_ON_CYC,  // lamp test length
	parameter int LAMP_OFF_CYCLES = LAMP_OFF_CYC  // dark gap after the test
) (
	input  wire logic        clk_in,                    // host bus clock
	input  wire logic        rst_in,                    // asynchronous, active high
	input  wire logic [7:0]  host_addr_in,              // byte address
	input  wire logic        host_wr_in,                // write strobe
	input  wire logic        host_rd_in,                // read strobe
	input  wire logic [31:0] host_wdata_in,             // write data
	output logic      [31:0] host_rdata_out,            // read data, one cycle after strobe
	input  wire logic [35:0] general_input_port_in,     // board and station input lines
	input  wire logic [3:0]  button_in,                 // vol up, vol down, squelch, intercom
	input  wire logic [7:0]  irq_source_in,             // eight monitored inputs
	input  wire logic        power_monitor_reset_in,    // power-up reset
	input  wire logic        manual_reset_in,           // front panel reset switch
	input  wire logic        sw_reset_in,               // host software reset
	input  wire logic        host_soft_reset_in,        // host soft reset line
	input  wire logic        bidir_hard_reset_in,       // level seen on the hard reset pin
	output logic             bidir_hard_reset_oe_n_out, // low while we pull the pin
	output logic             bidir_hard_reset_out,      // value driven on the pin
	output logic             board_reset_out,           // combined board reset
	input  wire logic [31:0] serial_id_in,              // station serial number lines
	output logic [31:0]      general_output_port_out,   // control lines
	output logic [7:0]       led_out,                   // front panel lamps
	output logic [2:0]       audio_select_out,          // codec input multiplexer
	output logic             host_interrupt_line_out    // interrupt to host
);
	// two-stage synchronisers for buttons and monitored inputs
	logic [11:0] sync1_r;  // first stage, read only by the second
	logic [11:0] sync2_r;  // usable synchronised copy
	logic [11:0] sync_src; // buttons above the monitored inputs
	assign sync_src = {button_in, irq_source_in};
	genvar g;
	generate
		for (g = 0; g < 12; g++) begin : g_sync
			always_ff @(posedge clk_in or posedge rst_in) begin
				if (rst_in) begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
				end else begin
					sync1_r[g] <= sync_src[g];
					sync2_r[g] <= sync1_r[g];
				end
			end
		end
	endgenerate
	logic [7:0] irq_sync;  // synchronised monitored inputs
	logic [3:0] btn_sync;  // synchronised pushbuttons
	assign irq_sync = sync2_r[7:0];
	assign btn_sync = sync2_r[11:8];

	// one-hot lamp phases
	typedef enum logic [2:0] {
		LAMP_TEST = 3'b001,
		LAMP_DARK = 3'b010,
		LAMP_RUN  = 3'b100
	} lamp_e;

	// register state
	logic [31:0] out_r, out_nxt;       // general_output_port
	logic [7:0]  mask_r, mask_nxt;     // interrupt mask
	logic [3:0]  ctl_r, ctl_nxt;       // edge select and audio select
	logic [7:0]  pend_r, pend_nxt;     // pending interrupt flags
	logic [7:0]  prev_r;               // last sample of monitored inputs
	logic [4:0]  cause_r, cause_nxt;   // sticky reset causes
	logic [31:0] id_r, id_nxt;         // serial id
	logic        id_done_r;            // id captured since reset release
	logic [31:0] rdata_nxt;            // read mux result
	logic        irq_nxt;              // next interrupt line
	logic        ref_lost;             // reference activity missing
	logic [4:0]  rst_src;              // present reset sources
	lamp_e       lamp_r, lamp_nxt;     // lamp phase
	logic [27:0] cnt_r, cnt_nxt;       // lamp phase timer
	logic [7:0]  led_nxt;              // next lamp pattern

	assign ref_lost = ~irq_sync[0];
	// hard reset pin seen only when we are not driving it ourselves
	assign rst_src  = {bidir_hard_reset_in & bidir_hard_reset_oe_n_out, host_soft_reset_in,
		sw_reset_in, manual_reset_in, power_monitor_reset_in};

	// decoded write strobe for a given offset
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = host_wr_in && (host_addr_in == ofs);
	endfunction

	// next values of host registers, flags and read data
	always_comb begin
		logic [7:0] edge_hit;
		edge_hit  = irq_sync & ~prev_r;
		out_nxt   = wr_hit(OFS_OUTPUT) ? host_wdata_in : out_r;
		mask_nxt  = wr_hit(OFS_IRQ_MASK) ? host_wdata_in[7:0] : mask_r;
		ctl_nxt   = wr_hit(OFS_CONTROL) ? host_wdata_in[3:0] : ctl_r;
		// dac status takes the selected edge
		edge_hit[IRQ_DAC_BIT] = ctl_r[CTL_DAC_EDGE] ?
			(~irq_sync[IRQ_DAC_BIT] & prev_r[IRQ_DAC_BIT]) :
			(irq_sync[IRQ_DAC_BIT] & ~prev_r[IRQ_DAC_BIT]);
		// host clear first, then a new event sets, so set wins
		pend_nxt  = pend_r & ~(wr_hit(OFS_IRQ_PEND) ? host_wdata_in[7:0] : 8'h00);
		pend_nxt  = pend_nxt | edge_hit;
		cause_nxt = cause_r & ~(wr_hit(OFS_RESET_CAUSE) ? host_wdata_in[4:0] : 5'h00);
		cause_nxt = cause_nxt | rst_src;
		id_nxt    = id_done_r ? id_r : serial_id_in;
		irq_nxt   = |(pend_nxt & mask_nxt);
		// read mux; unmapped addresses answer zero
		unique case (host_addr_in)
			OFS_INPUT_A:     rdata_nxt = {general_input_port_in[27:4], btn_sync, general_input_port_in[3:0]};
			OFS_INPUT_B:     rdata_nxt = {24'h00_0000, general_input_port_in[35:28]};
			OFS_OUTPUT:      rdata_nxt = out_r;
			OFS_RESET_CAUSE: rdata_nxt = {27'h000_0000, cause_r};
			OFS_IRQ_PEND:    rdata_nxt = {24'h00_0000, pend_r};
			OFS_IRQ_MASK:    rdata_nxt = {24'h00_0000, mask_r};
			OFS_CONTROL:     rdata_nxt = {28'h000_0000, ctl_r};
			OFS_SERIAL_ID:   rdata_nxt = id_r;
			OFS_STATUS:      rdata_nxt = {28'h000_0000, lamp_r, ref_lost};
			default:         rdata_nxt = 32'h0000_0000;
		endcase
		if (!host_rd_in) begin
			rdata_nxt = host_rdata_out;
		end
	end

	// host registers, flags and outputs
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_r                     <= OUTPUT_RST;
			mask_r                    <= IRQ_MASK_RST;
			ctl_r                     <= CONTROL_RST;
			pend_r                    <= 8'h00;
			prev_r                    <= 8'h00;
			cause_r                   <= 5'h00;
			id_r                      <= 32'h0000_0000;
			id_done_r                 <= 1'b0;
			host_rdata_out            <= 32'h0000_0000;
			host_interrupt_line_out   <= 1'b0;
			general_output_port_out   <= OUTPUT_RST;
			audio_select_out          <= 3'h0;
			board_reset_out           <= 1'b0;
			bidir_hard_reset_oe_n_out <= 1'b1;
			bidir_hard_reset_out      <= 1'b0;
		end else begin
			out_r                     <= out_nxt;
			mask_r                    <= mask_nxt;
			ctl_r                     <= ctl_nxt;
			pend_r                    <= pend_nxt;
			prev_r                    <= irq_sync;
			cause_r                   <= cause_nxt;
			id_r                      <= id_nxt;
			id_done_r                 <= 1'b1;
			host_rdata_out            <= rdata_nxt;
			host_interrupt_line_out   <= irq_nxt;
			general_output_port_out   <= out_nxt;
			audio_select_out          <= ctl_nxt[CTL_AUDIO_LSB +: 3];
			board_reset_out           <= |rst_src;
			bidir_hard_reset_oe_n_out <= ~(|rst_src[3:0]);
			bidir_hard_reset_out      <= |rst_src[3:0];
		end
	end

	// lamp phase: test, dark gap, then output port bits
	always_comb begin
		lamp_nxt = lamp_r;
		cnt_nxt  = cnt_r + 28'h000_0001;
		led_nxt  = out_nxt[7:0];
		unique case (lamp_r)
			LAMP_TEST: begin
				led_nxt = LED_ALL_LIT;
				if (cnt_r >= 28'(LAMP_ON_CYCLES)) begin
					lamp_nxt = LAMP_DARK;
					cnt_nxt  = 28'h000_0000;
					led_nxt  = LED_ALL_DARK;
				end
			end
			LAMP_DARK: begin
				led_nxt = LED_ALL_DARK;
				if (cnt_r >= 28'(LAMP_OFF_CYCLES - 1)) begin
					lamp_nxt = LAMP_RUN;
					cnt_nxt  = 28'h000_0000;
					led_nxt  = out_nxt[7:0];
				end
			end
			LAMP_RUN: begin
				cnt_nxt = cnt_r;
			end
		endcase
	end

	// lamp phase registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lamp_r  <= LAMP_TEST;
			cnt_r   <= 28'h000_0000;
			led_out <= OUTPUT_RST[7:0];
		end else begin
			lamp_r  <= lamp_nxt;
			cnt_r   <= cnt_nxt;
			led_out <= led_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_write_out;
		host_wr_in && host_addr_in == OFS_OUTPUT;
	endsequence
	sequence s_read_out;
		host_rd_in && host_addr_in == OFS_OUTPUT;
	endsequence
	property p_out_readback;
		s_write_out ##1 s_read_out |=> host_rdata_out == $past(host_wdata_in, 2);
	endproperty
	a_out_readback: assert property (p_out_readback) else $error("output port readback wrong");

	property p_port_drives;
		s_write_out |=> general_output_port_out == $past(host_wdata_in);
	endproperty
	a_port_drives: assert property (p_port_drives) else $error("output port not driven");

	property p_irq_line;
		host_interrupt_line_out == |(pend_r & mask_r);
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("interrupt line mismatch");

	property p_pend_sticky;
		pend_r[3] && !(host_wr_in && host_addr_in == OFS_IRQ_PEND) |=> pend_r[3];
	endproperty
	a_pend_sticky: assert property (p_pend_sticky) else $error("pending flag dropped");

	property p_dac_edge;
		ctl_r[CTL_DAC_EDGE] && $fell(irq_sync[IRQ_DAC_BIT]) |=> pend_r[IRQ_DAC_BIT];
	endproperty
	a_dac_edge: assert property (p_dac_edge) else $error("falling dac edge missed");

	property p_sync_delay;
		$rose(irq_source_in[2]) ##1 irq_source_in[2] |=> irq_sync[2];
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("synchroniser delay wrong");

	property p_reset_merge;
		manual_reset_in |=> board_reset_out && !bidir_hard_reset_oe_n_out && cause_r[1];
	endproperty
	a_reset_merge: assert property (p_reset_merge) else $error("manual reset not merged");

	property p_id_locked;
		id_done_r |=> $stable(id_r);
	endproperty
	a_id_locked: assert property (p_id_locked) else $error("serial id changed");

	sequence s_test_to_dark;
		lamp_r == LAMP_TEST ##1 lamp_r == LAMP_DARK;
	endsequence
	property p_lamp_order;
		s_test_to_dark |-> led_out == LED_ALL_DARK && cnt_r == 28'h000_0000;
	endproperty
	a_lamp_order: assert property (p_lamp_order) else $error("lamp test order wrong");

	property p_run_follows;
		lamp_r == LAMP_RUN && $past(lamp_r) == LAMP_RUN |-> led_out == general_output_port_out[7:0];
	endproperty
	a_run_follows: assert property (p_run_follows) else $error("lamps not following port");
endmodule

//--- dv/host_model.sv
/*
 * host processor model: one-cycle read and write strobes on the glue bus.
 * assumes the glue block takes strobes on rising clk_in edges and answers
 * a read on host_rdata one cycle later.
 */
`timescale 1ns/10ps
module host_model (
	input  wire logic        clk_in,    // bus clock
	output logic      [7:0]  addr_out,  // byte address
	output logic             wr_out,    // write strobe
	output logic             rd_out,    // read strobe
	output logic      [31:0] wdata_out, // write data
	input  wire logic [31:0] rdata_in   // read data
);
	// idle bus at time zero
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 32'h0000_0000;
	end
	// one write; released data is inverted so it never lingers as valid
	task automatic write(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	// one read; data taken one cycle after the strobe edge
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
	// a write followed at once by a read, no idle cycle between
	task automatic write_read(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = wd;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~wd;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
	endtask
endmodule

//--- dv/testbench.sv
/*
 * self-checking bench of the station glue logic with a host model.
 * assumes short lamp counts passed as parameters and 100 MHz clk_in.
 */
`timescale 1ns/10ps
module testbench;
	import station_io_pkg::*;
	logic        clk_in, rst_in, host_wr, host_rd, oe_n, hard_out, board_rst, irq;
	logic [7:0]  host_addr, irq_src, led;
	logic [31:0] host_wdata, host_rdata, sid, port, d, v;
	logic [35:0] gip;      // general input lines
	logic [3:0]  btn;      // pushbuttons
	logic [4:0]  rst_src;  // power, manual, sw, soft, hard pin drive
	logic [2:0]  audio;
	logic [31:0] seed = 32'h00dc18de;
	int          bad_count = 0;
	int          samples_checked = 0;
	wire         hard_wire = oe_n ? rst_src[4] : hard_out; // pin level
	// xorshift source of repeatable stimulus
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected input word at the low input address
	function logic [31:0] in_a(logic [35:0] g, logic [3:0] b);
		return {g[27:4], b, g[3:0]};
	endfunction
	localparam int LAMP_ON_TB  = 5; // short lamp test for simulation
	localparam int LAMP_OFF_TB = 8; // short dark gap for simulation
	station_io_glue_logic #(.LAMP_ON_CYCLES(LAMP_ON_TB), .LAMP_OFF_CYCLES(LAMP_OFF_TB)) i_station_io_glue_logic (
		.clk_in(clk_in), .rst_in(rst_in), .host_addr_in(host_addr), .host_wr_in(host_wr),
		.host_rd_in(host_rd), .host_wdata_in(host_wdata), .host_rdata_out(host_rdata),
		.general_input_port_in(gip), .button_in(btn), .irq_source_in(irq_src),
		.power_monitor_reset_in(rst_src[0]), .manual_reset_in(rst_src[1]), .sw_reset_in(rst_src[2]),
		.host_soft_reset_in(rst_src[3]), .bidir_hard_reset_in(hard_wire),
		.bidir_hard_reset_oe_n_out(oe_n), .bidir_hard_reset_out(hard_out), .board_reset_out(board_rst),
		.serial_id_in(sid), .general_output_port_out(port), .led_out(led), .audio_select_out(audio),
		.host_interrupt_line_out(irq));
	host_model i_host_model (.clk_in(clk_in), .addr_out(host_addr), .wr_out(host_wr), .rd_out(host_rd),
		.wdata_out(host_wdata), .rdata_in(host_rdata));
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// counts, verdict and end of run
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// lamp test after a reset release: lit, dark, then the port reset pattern 8'h00, fail lamp lit
	task lamp_walk();
		repeat (LAMP_ON_TB) begin
			@(negedge clk_in);
			chk(led, LED_ALL_LIT);
		end
		repeat (LAMP_OFF_TB) begin
			@(negedge clk_in);
			chk(led, LED_ALL_DARK);
		end
		@(negedge clk_in);
		chk(led, 8'h00);
	endtask
	// free-running clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
	// main sequence
	initial begin
		rst_in = 1'b1;
		gip = 36'h0;
		btn = 4'h0;
		irq_src = 8'h00;
		rst_src = 5'h00;
		sid = xs();
		repeat (10) @(negedge clk_in);
		chk(led, 8'h00);
		chk(port, 32'h0);
		rst_in = 1'b0;
		lamp_walk();
		// serial id readable, write ignored
		i_host_model.read(OFS_SERIAL_ID, d);
		chk(d, sid);
		i_host_model.write(OFS_SERIAL_ID, ~sid);
		i_host_model.read(OFS_SERIAL_ID, d);
		chk(d, sid);
		// output port, lamps and read back
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 32'hffff_ffbf : xs();
			i_host_model.write(OFS_OUTPUT, v);
			chk(port, v);
			chk(led, v[7:0]);
			i_host_model.read(OFS_OUTPUT, d);
			chk(d, v);
		end
		// a read straight after a write sees the new value
		v = xs();
		i_host_model.write_read(OFS_OUTPUT, v, d);
		chk(d, v);
		chk(port, v);
		// input ports and buttons through the synchroniser
		for (int k = 0; k < 4; k++) begin
			v = xs();
			gip = {v[3:0], xs()};
			btn = v[7:4];
			repeat (3) @(negedge clk_in);
			i_host_model.read(OFS_INPUT_A, d);
			chk(d, in_a(gip, btn));
			i_host_model.read(OFS_INPUT_B, d);
			chk(d, {24'h0, gip[35:28]});
		end
		i_host_model.read(8'hfc, d);
		chk(d, 32'h0);
		// every source raises the line and is cleared
		i_host_model.write(OFS_IRQ_MASK, 32'hff);
		for (int k = 0; k < 8; k++) begin
			irq_src = 8'h01 << k;
			repeat (6) @(negedge clk_in);
			chk(irq, 1'b1);
			i_host_model.read(OFS_IRQ_PEND, d);
			chk(d, 32'h1 << k);
			irq_src = 8'h00;
			i_host_model.write(OFS_IRQ_PEND, 32'h1 << k);
			@(negedge clk_in);
			chk(irq, 1'b0);
		end
		// masked source stays pending, unmask raises the line
		i_host_model.write(OFS_IRQ_MASK, 32'h0);
		irq_src = 8'h08;
		repeat (6) @(negedge clk_in);
		chk(irq, 1'b0);
		i_host_model.write(OFS_IRQ_MASK, 32'hff);
		@(negedge clk_in);
		chk(irq, 1'b1);
		i_host_model.write(OFS_IRQ_PEND, 32'hff);
		@(negedge clk_in);
		chk(irq, 1'b0);
		// falling edge selected for the dac status source
		i_host_model.write(OFS_CONTROL, 32'h1);
		irq_src = 8'h0a;
		repeat (6) @(negedge clk_in);
		chk(irq, 1'b0);
		irq_src = 8'h08;
		repeat (6) @(negedge clk_in);
		i_host_model.read(OFS_IRQ_PEND, d);
		chk(d, 32'h2);
		// all eight audio sources
		for (int k = 0; k < 8; k++) begin
			i_host_model.write(OFS_CONTROL, k << 1);
			chk(audio, k);
		end
		// reference lost follows the activity input
		irq_src = 8'h00;
		repeat (4) @(negedge clk_in);
		i_host_model.read(OFS_STATUS, d);
		chk(d[0], 1'b1);
		irq_src = 8'h01;
		repeat (4) @(negedge clk_in);
		i_host_model.read(OFS_STATUS, d);
		chk(d[0], 1'b0);
		// each reset source, its record and its clear
		for (int k = 0; k < 5; k++) begin
			rst_src[k] = 1'b1;
			repeat (2) @(negedge clk_in);
			chk(board_rst, 1'b1);
			chk(oe_n, k == 4);
			chk(hard_out, k != 4);
			rst_src[k] = 1'b0;
			repeat (3) @(negedge clk_in);
			chk(board_rst, 1'b0);
			i_host_model.read(OFS_RESET_CAUSE, d);
			chk(d, 32'h1 << k);
			i_host_model.write(OFS_RESET_CAUSE, 32'h1f);
		end
		// second reset in mid-run: reset values return, lamp test runs again
		@(negedge clk_in);
		rst_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk(led, 8'h00);
		chk(port, 32'h0);
		chk(irq, 1'b0);
		sid = xs();
		rst_in = 1'b0;
		lamp_walk();
		i_host_model.read(OFS_SERIAL_ID, d);
		chk(d, sid);
		i_host_model.read(OFS_IRQ_MASK, d);
		chk(d, 32'h0);
		wrap_up();
	end
endmodule
